// ---- shared/ssa_pkg.sv ----
// Constants and carrier types for the slave supervision block
package ssa_pkg;
  localparam int CLK_MHZ = 20;
  // Addressing channel timing, in ns
  localparam int BIT_NS = 6000;
  localparam int TOL_LATE_NS = 2000;
  localparam int TOL_EARLY_NS = 1000;
  localparam int PAUSE_NS = 9000;
  localparam logic [11:0] BIT_CYC = 12'(BIT_NS * CLK_MHZ / 1000);
  localparam logic [11:0] HALF_CYC = 12'(BIT_NS * CLK_MHZ / 2000);
  localparam logic [11:0] LATE_CYC = 12'(TOL_LATE_NS * CLK_MHZ / 1000);
  localparam logic [11:0] EARLY_CYC = 12'((TOL_EARLY_NS * CLK_MHZ + 999) / 1000);
  localparam logic [11:0] PAUSE_CYC = 12'((PAUSE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [3:0] END_BIT_N = 4'hd;
  localparam logic [1:0] SYNC_TAIL_BITS = 2'h1;
  localparam logic [1:0] UNSYNC_TAIL_BITS = 2'h3;
  // Supervision times, in us
  localparam int COMM_US = 40960;
  localparam int TOGGLE_US = 327000;
  localparam int COMM_CYC_DEF = COMM_US * CLK_MHZ;
  localparam int TOGGLE_CYC_DEF = TOGGLE_US * CLK_MHZ;
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_EXT1 = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_RXDATA = 8'h0c;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] EXT1_RESET = 32'h0000_0000;
  // Operating modes
  typedef enum logic [1:0] {
    MODE_SLAVE = 2'b00,
    MODE_MASTER = 2'b01,
    MODE_REPEATER = 2'b10,
    MODE_MONITOR = 2'b11
  } ssa_mode_t;
  // Control register layout, high bits first
  typedef struct packed {
    logic [16:0] spare;
    logic [3:0] id_code;
    logic [4:0] slave_addr;
    logic ext_id1_lock_flag;
    logic four_in_four_out_select;
    logic port0_wdog_select_flag;
    logic wdog_active;
    logic [1:0] mode;
  } ssa_ctrl_t;
  // Telegram error flags
  typedef struct packed {
    logic length;
    logic end_bit;
    logic parity;
    logic no_info;
    logic start_bit;
  } ssa_err_t;
endpackage

// ---- rtl/ssa_supervisor.sv ----
// Addressing channel checker, state guard, communication and toggle watchdogs, ID1 lock
// Summary of operation
// - Idle high; falling start, rising end, pause
// - Mid-bit falling is zero, rising is one
// - Check only in slave mode; otherwise pass through
// - First edge after pause not falling: error
// - Edges within n*6us +2/-1us, n 1..13
// - Odd parity over info bits is error
// - Edge at 78us must rise, closes request
// - Non-pause after end bit is length error
// - Error: discard, no strobe, unsync, await pause
// - Prohibited main state forces slave reset
// - No exchange 40.96ms: status, red lamp on (lit only outside watchdog mode; in watchdog mode the reset wins)
// - Monitor armed at nonzero address, first parameter
// - Watchdog mode: enable flag or port0 condition
// - Watchdog timeout resets device, blocks exchange
// - Exchange blocked until next parameter write
// - Toggle watchdog enabled on first output event
// - Toggle watchdog needs 4I/4O plus watchdog mode
// - No toggle for 327ms: same reset
// - Lock set: read reply from locked copy
// - Lock and extended mode: bit 3 user
// - Lock: mismatching write fully ignored
// - Lock clear: user copy, writes answered
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ps
module ssa_supervisor
  import ssa_pkg::*;
#(
  parameter int COMM_CYC = COMM_CYC_DEF,
  parameter int TOGGLE_CYC = TOGGLE_CYC_DEF,
  parameter logic [3:0] FOUR_IO_ID = 4'h5, // Arbitrary value
  parameter logic [3:0] LAST_LEGAL_STATE = 4'h9
)(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Addressing channel
  input wire logic aux_addr_input,
  output logic manchester_drive,
  output logic rx_strobe,
  output logic [11:0] rx_data,
  output ssa_err_t rx_err,
  // Main state machine events
  input wire logic [3:0] main_state,
  input wire logic data_exchange_done,
  input wire logic write_param_done,
  input wire logic delete_addr_done,
  input wire logic data_output_event,
  input wire logic toggle_bit,
  input wire logic param_port_zero,
  input wire logic ext_addr_mode,
  // Supervision results
  output logic slave_reset,
  output logic wdog_reset,
  output logic exchange_block,
  output logic red_fault_lamp,
  // ID code extension 1 requests
  input wire logic ext1_read_req,
  input wire logic ext1_write_req,
  input wire logic [3:0] ext1_write_data,
  output logic ext1_reply,
  output logic [3:0] ext1_reply_data,
  output logic eeprom_write
);
  typedef enum logic [1:0] {
    RX_WAIT_PAUSE = 2'b00,
    RX_IDLE = 2'b01,
    RX_RECV = 2'b10,
    RX_TAIL = 2'b11
  } ssa_rx_t;

  function automatic logic [11:0] mid_of(input logic [3:0] n);
    mid_of = 12'(n * BIT_CYC);
  endfunction

  ssa_ctrl_t ctrl;
  logic [3:0] user_ext_id1;
  logic [3:0] locked_ext_id1_copy;
  ssa_err_t err_sticky;
  ssa_rx_t rx_state;
  logic [11:0] rcnt;
  logic [3:0] wn;
  logic [11:0] shreg;
  logic synced;
  logic in_q;
  logic comm_armed;
  logic [23:0] comm_cnt;
  logic tog_enabled;
  logic tog_last;
  logic [23:0] tog_cnt;

  wire slave_mode = ctrl.mode == MODE_SLAVE;
  wire edge_seen = aux_addr_input != in_q;
  wire rising = edge_seen && aux_addr_input;
  wire [11:0] win_lo = mid_of(wn) - EARLY_CYC;
  wire [11:0] win_hi = mid_of(wn) + LATE_CYC;
  wire in_window = rcnt >= win_lo && rcnt <= win_hi;
  wire [11:0] tail_len = HALF_CYC
    + mid_of({2'b00, synced ? SYNC_TAIL_BITS : UNSYNC_TAIL_BITS});
  wire wdog_mode = ctrl.wdog_active
    || (ctrl.port0_wdog_select_flag && param_port_zero);
  wire tog_active = ctrl.id_code == FOUR_IO_ID
    && ctrl.four_in_four_out_select && wdog_mode;
  wire comm_expired = comm_armed && comm_cnt >= 24'(COMM_CYC);
  wire tog_expired = tog_enabled && tog_active && tog_cnt >= 24'(TOGGLE_CYC);
  wire wdog_fire = (comm_expired && wdog_mode) || tog_expired;
  wire illegal_state = main_state > LAST_LEGAL_STATE;
  wire any_reset = wdog_fire || illegal_state;
  wire addr_nonzero = ctrl.slave_addr != 5'h00;
  wire lock_match = ext_addr_mode ? ext1_write_data[2:0] == locked_ext_id1_copy[2:0]
    : ext1_write_data == locked_ext_id1_copy;
  wire ext1_write_ok = ext1_write_req && (!ctrl.ext_id1_lock_flag || lock_match);
  wire apb_do = psel && penable && pready;
  wire apb_wr = apb_do && pwrite;
  ssa_err_t next_err;

  // Input history and transparent forwarding outside slave mode
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      in_q <= 1'b1;
      manchester_drive <= 1'b1;
    end
    else
    begin
      in_q <= aux_addr_input;
      manchester_drive <= slave_mode ? 1'b1 : aux_addr_input;
    end
  end

  // Telegram receiver and checker
  always_comb
  begin
    next_err = '0;
    if (slave_mode)
    begin
      case (rx_state)
        RX_IDLE: next_err.start_bit = rising;
        RX_RECV:
        begin
          if (edge_seen && in_window && wn == END_BIT_N)
          begin
            next_err.end_bit = !rising;
            next_err.parity = rising && ^shreg;
          end
          else if (rcnt > win_hi)
            next_err.no_info = 1'b1;
        end
        RX_TAIL: next_err.length = edge_seen;
        default: next_err = '0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rx_state <= RX_WAIT_PAUSE;
      rcnt <= 12'h000;
      wn <= 4'h1;
      shreg <= 12'h000;
      synced <= 1'b0;
      rx_strobe <= 1'b0;
      rx_data <= 12'h000;
      rx_err <= '0;
    end
    else
    begin
      rx_strobe <= 1'b0;
      rx_err <= next_err;
      rcnt <= rcnt + 12'h001;
      if (!slave_mode)
      begin
        rx_state <= RX_WAIT_PAUSE;
        rcnt <= 12'h000;
        synced <= 1'b0;
      end
      else if (next_err != '0)
      begin
        rx_state <= RX_WAIT_PAUSE;
        rcnt <= 12'h000;
        synced <= 1'b0;
      end
      else
      begin
        case (rx_state)
          RX_WAIT_PAUSE:
          begin
            if (edge_seen)
              rcnt <= 12'h000;
            else if (rcnt >= PAUSE_CYC)
              rx_state <= RX_IDLE;
          end
          RX_IDLE:
          begin
            if (edge_seen)
            begin
              rx_state <= RX_RECV;
              rcnt <= 12'h000;
              wn <= 4'h1;
            end
          end
          RX_RECV:
          begin
            // Edges between windows are bit-boundary transitions and are ignored
            if (edge_seen && in_window)
            begin
              if (wn == END_BIT_N)
              begin
                rx_state <= RX_TAIL;
                rcnt <= 12'h000;
              end
              else
              begin
                shreg <= {shreg[10:0], rising};
                wn <= wn + 4'h1;
              end
            end
          end
          RX_TAIL:
          begin
            if (rcnt >= tail_len)
            begin
              rx_state <= RX_IDLE;
              rx_strobe <= 1'b1;
              rx_data <= shreg;
              synced <= 1'b1;
            end
          end
          default: rx_state <= RX_WAIT_PAUSE;
        endcase
      end
    end
  end

  // Communication monitor
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      comm_armed <= 1'b0;
      comm_cnt <= 24'h000000;
      red_fault_lamp <= 1'b0;
    end
    else if (any_reset || delete_addr_done)
    begin
      comm_armed <= 1'b0;
      comm_cnt <= 24'h000000;
      red_fault_lamp <= red_fault_lamp && !any_reset;
    end
    else if ((write_param_done && addr_nonzero) || (comm_armed && data_exchange_done))
    begin
      comm_armed <= 1'b1;
      comm_cnt <= 24'h000000;
      red_fault_lamp <= 1'b0;
    end
    else if (comm_armed)
    begin
      if (comm_expired)
        red_fault_lamp <= 1'b1;
      else
        comm_cnt <= comm_cnt + 24'h000001;
    end
  end

  // Toggle watchdog
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tog_enabled <= 1'b0;
      tog_last <= 1'b0;
      tog_cnt <= 24'h000000;
    end
    else if (any_reset || delete_addr_done)
    begin
      tog_enabled <= 1'b0;
      tog_cnt <= 24'h000000;
    end
    else if (!tog_enabled)
    begin
      tog_enabled <= data_output_event && addr_nonzero;
      tog_last <= toggle_bit;
      tog_cnt <= 24'h000000;
    end
    else if (data_exchange_done && toggle_bit != tog_last)
    begin
      tog_last <= toggle_bit;
      tog_cnt <= 24'h000000;
    end
    else if (!tog_expired)
      tog_cnt <= tog_cnt + 24'h000001;
  end

  // Reset requests and exchange block
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      slave_reset <= 1'b0;
      wdog_reset <= 1'b0;
      exchange_block <= 1'b0;
    end
    else
    begin
      slave_reset <= any_reset;
      wdog_reset <= wdog_fire;
      if (wdog_fire)
        exchange_block <= 1'b1;
      else if (write_param_done)
        exchange_block <= 1'b0;
    end
  end

  // ID code extension 1 requests
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ext1_reply <= 1'b0;
      ext1_reply_data <= 4'h0;
      eeprom_write <= 1'b0;
    end
    else
    begin
      ext1_reply <= ext1_read_req || ext1_write_ok;
      eeprom_write <= ext1_write_ok;
      if (ext1_read_req)
      begin
        if (!ctrl.ext_id1_lock_flag)
          ext1_reply_data <= user_ext_id1;
        else if (ext_addr_mode)
          ext1_reply_data <= {user_ext_id1[3], locked_ext_id1_copy[2:0]};
        else
          ext1_reply_data <= locked_ext_id1_copy;
      end
      else if (ext1_write_ok)
        ext1_reply_data <= ext1_write_data;
    end
  end

  // Register file
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl <= CTRL_RESET;
      user_ext_id1 <= EXT1_RESET[3:0];
      locked_ext_id1_copy <= EXT1_RESET[7:4];
      err_sticky <= '0;
    end
    else
    begin
      if (apb_wr && paddr == ADDR_CTRL)
        ctrl <= pwdata;
      if (ext1_write_ok)
        user_ext_id1 <= ext1_write_data;
      else if (apb_wr && paddr == ADDR_EXT1)
        user_ext_id1 <= pwdata[3:0];
      if (apb_wr && paddr == ADDR_EXT1)
        locked_ext_id1_copy <= pwdata[7:4];
      // A new error wins over a write-one clear in the same cycle
      if (apb_wr && paddr == ADDR_STATUS)
        err_sticky <= (err_sticky & ~ssa_err_t'(pwdata[4:0])) | next_err;
      else
        err_sticky <= err_sticky | next_err;
    end
  end

  // APB answer, one wait state so read data leaves a flip-flop
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= psel && penable && !pready;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && penable && !pready)
      begin
        case (paddr)
          ADDR_CTRL: prdata <= ctrl;
          ADDR_EXT1: prdata <= {24'h000000, locked_ext_id1_copy, user_ext_id1};
          ADDR_STATUS: prdata <= {16'h0000, 4'h0, exchange_block,
            red_fault_lamp, tog_enabled, comm_armed, synced, 2'b00, err_sticky};
          ADDR_RXDATA: prdata <= {20'h00000, rx_data};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end
endmodule

// ---- verification/ssa_supervisor_properties.sv ----
// Port-level assertions for the slave supervision block
`timescale 1ns/1ps
module ssa_supervisor_properties
  import ssa_pkg::*;
#(
  parameter int COMM_CYC = COMM_CYC_DEF,
  parameter logic [3:0] LAST_LEGAL_STATE = 4'h9
)(
  // Clock, reset and APB
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  // Addressing channel
  input wire logic aux_addr_input,
  input wire logic manchester_drive,
  input wire logic rx_strobe,
  input wire logic [11:0] rx_data,
  input wire ssa_err_t rx_err,
  // Supervision and ID1
  input wire logic [3:0] main_state,
  input wire logic data_exchange_done,
  input wire logic write_param_done,
  input wire logic slave_reset,
  input wire logic wdog_reset,
  input wire logic exchange_block,
  input wire logic red_fault_lamp,
  input wire logic ext_addr_mode,
  input wire logic ext1_write_req,
  input wire logic [3:0] ext1_write_data,
  input wire logic ext1_reply,
  input wire logic eeprom_write
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  logic [1:0] mode_q;
  logic lock_q;
  logic [3:0] loc_q;
  logic nslv;
  logic bad_wr;
  int quiet;
  assign nslv = mode_q != 2'h0;
  assign bad_wr = ext_addr_mode ? ext1_write_data[2:0] != loc_q[2:0] : ext1_write_data != loc_q;
  // Shadow of the configuration, since mode and lock are not visible at the ports
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      mode_q <= 2'h0;
      lock_q <= 1'b0;
    end
    else if (psel && penable && pready && pwrite && paddr == ADDR_CTRL)
    begin
      mode_q <= pwdata[1:0];
      lock_q <= pwdata[5];
    end
  always_ff @(posedge clk or posedge rst)
    if (rst)
      loc_q <= 4'h0;
    else if (psel && penable && pready && pwrite && paddr == ADDR_EXT1)
      loc_q <= pwdata[7:4];
  // Cycles since the last exchange or parameter request
  always_ff @(posedge clk or posedge rst)
    if (rst)
      quiet <= 0;
    else
      quiet <= (data_exchange_done || write_param_done) ? 0 : quiet + 1;
  property p_pass; nslv && $past(nslv) |-> manchester_drive == $past(aux_addr_input);
  endproperty
  a_pass: assert property (p_pass) else $error("drive not following input");
  property p_parity; rx_strobe |-> ^rx_data == 1'b0; endproperty
  a_parity: assert property (p_parity) else $error("strobe with odd parity");
  property p_err; |rx_err |-> !rx_strobe [*8]; endproperty
  a_err: assert property (p_err) else $error("strobe after error");
  property p_illegal; main_state > LAST_LEGAL_STATE |=> slave_reset; endproperty
  a_illegal: assert property (p_illegal) else $error("no reset on bad state");
  property p_lamp; $rose(red_fault_lamp) |-> quiet >= COMM_CYC && quiet <= COMM_CYC * 21 / 20;
  endproperty
  a_lamp: assert property (p_lamp) else $error("lamp at wrong time");
  property p_wdog; wdog_reset |-> slave_reset ##1 exchange_block; endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog reset incomplete");
  property p_block; $fell(exchange_block) |-> $past(write_param_done); endproperty
  a_block: assert property (p_block) else $error("block cleared early");
  property p_lock_wr; ext1_write_req && lock_q && bad_wr |=> !ext1_reply && !eeprom_write;
  endproperty
  a_lock_wr: assert property (p_lock_wr) else $error("locked write processed");
  property p_open_wr; ext1_write_req && !lock_q |=> ext1_reply && eeprom_write; endproperty
  a_open_wr: assert property (p_open_wr) else $error("open write ignored");
  c_strobe: cover property (rx_strobe);
  c_wdog: cover property (wdog_reset);
  c_lock: cover property (ext1_write_req && lock_q && bad_wr);
endmodule
bind ssa_supervisor ssa_supervisor_properties #(
  .COMM_CYC(COMM_CYC), .LAST_LEGAL_STATE(LAST_LEGAL_STATE)) i_props (.clk, .rst, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pready, .aux_addr_input, .manchester_drive,
  .rx_strobe, .rx_data, .rx_err, .main_state, .data_exchange_done, .write_param_done,
  .slave_reset, .wdog_reset, .exchange_block, .red_fault_lamp, .ext_addr_mode,
  .ext1_write_req, .ext1_write_data, .ext1_reply, .eeprom_write);

// ---- verification/ssa_tool_model.sv ----
// Addressing tool model that sends Manchester telegrams
`timescale 1ns/1ps
module ssa_tool_model
  import ssa_pkg::*;
(
  // Clock
  input wire logic clk,
  // Addressing channel
  output logic aux_addr_input
);
  initial aux_addr_input = 1'b1;
  task automatic half(input logic v, input int n);
    aux_addr_input <= v;
    repeat (n) @(posedge clk);
  endtask
  // Boundary level first, so every bit has its mid-bit edge
  task automatic send(input logic [11:0] d, input logic bad_end, input logic extra);
    half(1'b0, HALF_CYC);
    for (int i = 11; i >= 0; i--)
    begin
      half(!d[i], HALF_CYC);
      half(d[i], HALF_CYC);
    end
    half(bad_end, HALF_CYC);
    half(!bad_end, HALF_CYC);
    if (extra)
      half(1'b0, HALF_CYC);
    half(1'b1, 400);
  endtask
endmodule

// ---- verification/tb_top.sv ----
// Testbench for the slave supervision block
`timescale 1ns/1ps
module tb_top
  import ssa_pkg::*;
;
  localparam int CC = 200;
  localparam logic [3:0] FID = 4'h3; // Arbitrary value
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, se;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic manchester_drive, rx_strobe, aux_addr_input, slave_reset, wdog_reset, eeprom_write;
  logic exchange_block, red_fault_lamp, ext1_reply, lk, ai_q = 1'b1, md = 1'b0;
  logic [11:0] rx_data, d;
  ssa_err_t rx_err;
  logic [3:0] main_state = 4'h0, evv = 4'h0, ext1_write_data = 4'h0, ext1_reply_data, loc, usr;
  logic data_exchange_done, write_param_done, delete_addr_done, data_output_event;
  logic toggle_bit = 1'b0, param_port_zero = 1'b0, ext_addr_mode = 1'b0;
  logic ext1_read_req = 1'b0, ext1_write_req = 1'b0;
  logic [4:0] errs = 5'h0, e0;
  logic [11:0] q[$];
  int failures = 0, tests_run = 0, nstb = 0, nwd = 0, k;
  assign {delete_addr_done, data_output_event, write_param_done, data_exchange_done} = evv;
  ssa_supervisor #(.COMM_CYC(CC), .TOGGLE_CYC(300), .FOUR_IO_ID(FID)) i_ssa_supervisor (
    .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .aux_addr_input, .manchester_drive, .rx_strobe, .rx_data, .rx_err, .main_state,
    .data_exchange_done, .write_param_done, .delete_addr_done, .data_output_event,
    .toggle_bit, .param_port_zero, .ext_addr_mode, .slave_reset, .wdog_reset,
    .exchange_block, .red_fault_lamp, .ext1_read_req, .ext1_write_req, .ext1_write_data,
    .ext1_reply, .ext1_reply_data, .eeprom_write);
  ssa_tool_model i_ssa_tool_model (.clk, .aux_addr_input);
  initial
  begin
    forever #25 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_sim();
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Reference receiver: every strobe must match the oldest word sent
  always @(posedge clk)
  begin
    errs <= errs | rx_err;
    nwd <= nwd + (wdog_reset === 1'b1);
    ai_q <= aux_addr_input;
    // Outside slave mode the drive repeats the input one cycle late
    if (md)
      chk("manchester_drive", ai_q, manchester_drive);
    if (rx_strobe === 1'b1)
    begin
      nstb <= nstb + 1;
      chk("rx_data", q.size() > 0 ? q.pop_front() : 12'hxxx, rx_data);
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] x);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= x;
    @(posedge clk);
    penable <= 1'b1;
    // Only the bench watchdog ends this wait
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rv = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // f holds lock, 4I/4O, port0 select, watchdog enable and mode
  task automatic cfg(input logic [3:0] id, input logic [4:0] a, input logic [5:0] f);
    apb(1'b1, ADDR_CTRL, {17'h0, id, a, f});
  endtask
  task automatic ev(input logic [3:0] m);
    evv <= m;
    @(posedge clk);
    evv <= 4'h0;
    @(posedge clk);
  endtask
  task automatic id1(input logic w, input logic [3:0] x);
    logic ok;
    ok = !lk || (ext_addr_mode ? x[2:0] == loc[2:0] : x == loc);
    ext1_write_req <= w;
    ext1_read_req <= !w;
    ext1_write_data <= x;
    @(posedge clk);
    ext1_write_req <= 1'b0;
    ext1_read_req <= 1'b0;
    @(posedge clk);
    if (w)
    begin
      chk("ext1_reply", ok, ext1_reply);
      chk("eeprom_write", ok, eeprom_write);
      usr = ok ? x : usr;
    end
    else
      chk("ext1_reply_data", !lk ? usr : ext_addr_mode ? {usr[3], loc[2:0]} : loc,
          ext1_reply_data);
    @(posedge clk);
  endtask
  initial
  begin
    repeat (40000) @(posedge clk);
    failures++;
    end_sim();
  end
  initial
  begin
    void'($urandom(32'hcb00));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl", CTRL_RESET, rv);
    apb(1'b0, ADDR_EXT1, 32'h0);
    chk("ext1", EXT1_RESET, rv);
    apb(1'b0, 8'h10, 32'h0);
    chk("pslverr", 1, se);
    // The receiver needs a full pause after reset before it takes a telegram
    repeat (PAUSE_CYC) @(posedge clk);
    repeat (3)
    begin
      d = {11'($urandom), 1'b0};
      d[0] = ^d[11:1];
      q.push_back(d);
      i_ssa_tool_model.send(d, 1'b0, 1'b0);
    end
    chk("strobes", 3, nstb);
    apb(1'b0, ADDR_RXDATA, 32'h0);
    chk("rxdata reg", {20'h00000, d}, rv);
    // Parity, end bit and length faults, then a clean telegram to show recovery
    for (k = 0; k < 4; k++)
    begin
      d = {11'($urandom), 1'b0};
      d[0] = ^d[11:1] ^ (k == 0);
      e0 = errs;
      if (k == 3)
        q.push_back(d);
      i_ssa_tool_model.send(d, k == 1, k == 2);
      chk("error flag", k < 3, errs[k % 3 + 2] && !e0[k % 3 + 2]);
    end
    chk("strobes", 4, nstb);
    e0 = errs;
    i_ssa_tool_model.half(1'b0, 400);
    i_ssa_tool_model.half(1'b1, 400);
    chk("start and info errors", 5'h03, errs & ~e0 & 5'h03);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status", 32'h0000_001f, rv);
    md <= 1'b1;
    for (k = 1; k < 4; k++)
    begin
      cfg(4'h0, 5'h0, 6'(k));
      i_ssa_tool_model.send(12'h5a5, 1'b0, 1'b0);
    end
    md <= 1'b0;
    chk("strobes", 4, nstb);
    cfg(4'h0, 5'h5, 6'h08);
    ev(4'h2);
    repeat (CC + 20) @(posedge clk);
    chk("lamp", 1, red_fault_lamp);
    chk("wdog", 0, nwd);
    ev(4'h1);
    chk("lamp", 0, red_fault_lamp);
    // Disarm first, so a monitor left running cannot fire in the cases below
    ev(4'h8);
    for (k = 0; k < 2; k++)
    begin
      cfg(4'h0, 5'(5 * k), 6'h04);
      ev(4'h2);
      if (k)
        ev(4'h8);
      repeat (CC + 20) @(posedge clk);
      chk("lamp", 0, red_fault_lamp);
      chk("wdog", 0, nwd);
    end
    param_port_zero <= 1'b1;
    cfg(4'h0, 5'h5, 6'h08);
    ev(4'h2);
    repeat (CC + 20) @(posedge clk);
    chk("wdog", 1, nwd);
    chk("block", 1, exchange_block);
    ev(4'h2);
    chk("block", 0, exchange_block);
    cfg(FID, 5'h5, 6'h14);
    ev(4'h2);
    ev(4'h4);
    for (k = 0; k < 19; k++)
    begin
      if (k == 9)
      begin
        chk("wdog", 2, nwd);
        ev(4'h2);
        ev(4'h4);
      end
      toggle_bit <= k > 9 && k[0];
      ev(4'h1);
      repeat (48) @(posedge clk);
    end
    chk("wdog", 2, nwd);
    ev(4'h8);
    apb(1'b1, ADDR_EXT1, 32'h69);
    {loc, usr, lk} = {4'h6, 4'h9, 1'b1};
    cfg(4'h0, 5'h5, 6'h20);
    id1(1'b0, 4'h0);
    ext_addr_mode <= 1'b1;
    @(posedge clk);
    id1(1'b0, 4'h0);
    id1(1'b1, 4'h5);
    id1(1'b1, {~usr[3], loc[2:0]});
    id1(1'b0, 4'h0);
    lk = 1'b0;
    cfg(4'h0, 5'h5, 6'h00);
    id1(1'b1, 4'($urandom));
    id1(1'b0, 4'h0);
    main_state <= 4'ha;
    repeat (2) @(posedge clk);
    chk("slave_reset", 1, slave_reset);
    main_state <= 4'h9;
    repeat (4) @(posedge clk);
    chk("slave_reset", 0, slave_reset);
    end_sim();
  end
endmodule
